// *** mfr_map.svh ***
`ifndef MFR_MAP_SVH
`define MFR_MAP_SVH

// Register byte offsets, one aligned 32-bit word each
`define MFR_ADDR_W           12
`define MFR_OFS_FIFO_CTRL    12'h000
`define MFR_OFS_DEPTH_INFO   12'h004
`define MFR_OFS_SOFT_RESET   12'h008
`define MFR_OFS_STA_ADDR_LO  12'h00c

// Threshold control fields
`define MFR_RXLVL_MSB        22
`define MFR_RXLVL_LSB        16
`define MFR_RXLVL_W          7
`define MFR_RXLVL_RST        7'h02
`define MFR_TXCNT_MSB        4
`define MFR_TXCNT_LSB        0
`define MFR_TXCNT_W          5
`define MFR_TXCNT_RST        5'h18

// Depth and configuration info fields
`define MFR_TXTOT_MSB        31
`define MFR_TXTOT_LSB        24
`define MFR_RXTOT_MSB        23
`define MFR_RXTOT_LSB        16
`define MFR_KIND_MSB         15
`define MFR_KIND_LSB         8
`define MFR_SETUP_MSB        7
`define MFR_SETUP_LSB        0
`define MFR_TXTOT_RST        8'h03
`define MFR_RXTOT_RST        8'h03
`define MFR_KIND_RST         8'h01
`define MFR_SETUP_RST        8'h01

// Soft reset and station address fields
`define MFR_SRST_BIT         0
`define MFR_SA0_MSB          15
`define MFR_SA0_LSB          8
`define MFR_SA1_MSB          7
`define MFR_SA1_LSB          0
`define MFR_SA_RST           8'h00

`endif

// *** mfr_pkg.sv ***
`include "mfr_map.svh"

package mfr_pkg;

   typedef enum logic [2:0] {
      SRST_IDLE = 3'b001,
      SRST_WAIT = 3'b010,
      SRST_FIRE = 3'b100
   } mfr_srst_t;

   typedef struct packed {
      logic [`MFR_RXLVL_W-1:0] rx_lvl;
      logic [`MFR_TXCNT_W-1:0] tx_cnt;
      logic [7:0]              sa0;
      logic [7:0]              sa1;
      mfr_srst_t               srst;
      logic                    mac_rst;
      logic                    rx_trig;
      logic                    tx_go;
      logic [31:0]             rdata;
      logic                    slverr;
   } mfr_state_t;

endpackage : mfr_pkg

// *** mfr_regs.sv ***
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`include "mfr_map.svh"

// Functional notes
// - Rx flow level in 22-16 triggers flow control
// - Rx flow level resets to two cells
// - Tx start count in 4-0, resets 24
// - Short packet starts once fully buffered
// - Tx FIFO cell total read-only, 31-24
// - Rx FIFO cell total read-only, 23-16
// - Writing one to bit 0 resets MAC
// - Reset waits until both DMAs idle
// - Bit reads one until reset completes
// - Station address bytes 0 and 1, writable
module mfr_regs
   import mfr_pkg::*;
#(
   parameter int unsigned TX_FIFO_CELLS = `MFR_TXTOT_RST,
   parameter int unsigned RX_FIFO_CELLS = `MFR_RXTOT_RST,
   parameter int unsigned ADDR_KIND     = `MFR_KIND_RST,
   parameter int unsigned SETUP_VALUE   = `MFR_SETUP_RST
) (
   input  wire logic                    clock,                 // 100 MHz clock
   input  wire logic                    sys_rst,               // Async reset, high
   input  wire logic                    psel,                  // APB select
   input  wire logic                    penable,               // APB access phase
   input  wire logic                    pwrite,                // APB write
   input  wire logic [`MFR_ADDR_W-1:0]  paddr,                 // APB byte address
   input  wire logic [31:0]             pwdata,                // APB write data
   input  wire logic [3:0]              pstrb,                 // APB byte strobes
   output logic [31:0]                  prdata,                // APB read data
   output logic                         pready,                // APB ready
   output logic                         pslverr,               // APB error
   input  wire logic                    rx_flow_en,            // Rx FIFO flow ctl on
   input  wire logic [7:0]              rx_fifo_used,          // Rx FIFO occupancy
   output logic                         rx_flow_trigger,       // Rx flow request
   input  wire logic [7:0]              tx_pkt_cells,          // Cells of head packet
   input  wire logic                    tx_pkt_whole,          // Head packet complete
   output logic                         tx_start_allow,        // Tx may start
   input  wire logic                    rx_dma_idle,           // Rx DMA idle
   input  wire logic                    tx_dma_idle,           // Tx DMA idle
   output logic                         mac_soft_rst,          // MAC reset pulse
   output logic [`MFR_RXLVL_W-1:0]      rx_flow_trigger_level, // Rx level value
   output logic [`MFR_TXCNT_W-1:0]      tx_start_cell_count,   // Tx count value
   output logic [7:0]                   station_addr_byte_zero,// Address byte 0
   output logic [7:0]                   station_addr_byte_one  // Address byte 1
);

   if (TX_FIFO_CELLS > 255 || RX_FIFO_CELLS > 255 ||
       ADDR_KIND > 255 || SETUP_VALUE > 255) begin : g_chk
      $error("mfr_regs: info fields are limited to 8 bits");
   end

   localparam logic [7:0] TX_TOT = 8'(TX_FIFO_CELLS);
   localparam logic [7:0] RX_TOT = 8'(RX_FIFO_CELLS);
   localparam logic [7:0] KIND   = 8'(ADDR_KIND);
   localparam logic [7:0] SETUP  = 8'(SETUP_VALUE);

   localparam mfr_state_t ST_RST = '{
      rx_lvl:  `MFR_RXLVL_RST,
      tx_cnt:  `MFR_TXCNT_RST,
      sa0:     `MFR_SA_RST,
      sa1:     `MFR_SA_RST,
      srst:    SRST_IDLE,
      mac_rst: 1'b0,
      rx_trig: 1'b0,
      tx_go:   1'b0,
      rdata:   32'h0000_0000,
      slverr:  1'b0
   };

   mfr_state_t st_r;
   mfr_state_t st_nxt;

   logic        setup_ph;
   logic        wr_take;
   logic        hit_fifo;
   logic        hit_info;
   logic        hit_srst;
   logic        hit_sa;
   logic        mapped;
   logic [31:0] wmask;
   logic [31:0] fifo_word;
   logic [31:0] info_word;
   logic [31:0] srst_word;
   logic [31:0] sa_word;
   logic        srst_req;
   logic        dma_quiet;

   // Zero wait state; read data is captured in the setup cycle
   assign pready   = 1'b1;
   assign setup_ph = psel && !penable;
   assign wr_take  = psel && penable && pwrite;

   assign hit_fifo = (paddr == `MFR_OFS_FIFO_CTRL);
   assign hit_info = (paddr == `MFR_OFS_DEPTH_INFO);
   assign hit_srst = (paddr == `MFR_OFS_SOFT_RESET);
   assign hit_sa   = (paddr == `MFR_OFS_STA_ADDR_LO);
   assign mapped   = hit_fifo || hit_info || hit_srst || hit_sa;

   assign dma_quiet = rx_dma_idle && tx_dma_idle;
   assign srst_req  = wr_take && hit_srst && wmask[`MFR_SRST_BIT] &&
                      pwdata[`MFR_SRST_BIT];

   always_comb begin
      for (int i = 0; i < 32; i++) begin
         wmask[i] = pstrb[i / 8];
      end
   end

   // Read words; bits outside the fields stay zero
   always_comb begin
      fifo_word = 32'h0000_0000;
      fifo_word[`MFR_RXLVL_MSB:`MFR_RXLVL_LSB] = st_r.rx_lvl;
      fifo_word[`MFR_TXCNT_MSB:`MFR_TXCNT_LSB] = st_r.tx_cnt;
      info_word = 32'h0000_0000;
      info_word[`MFR_TXTOT_MSB:`MFR_TXTOT_LSB] = TX_TOT;
      info_word[`MFR_RXTOT_MSB:`MFR_RXTOT_LSB] = RX_TOT;
      info_word[`MFR_KIND_MSB:`MFR_KIND_LSB]   = KIND;
      info_word[`MFR_SETUP_MSB:`MFR_SETUP_LSB] = SETUP;
      srst_word = 32'h0000_0000;
      srst_word[`MFR_SRST_BIT] = (st_r.srst != SRST_IDLE);
      sa_word = 32'h0000_0000;
      sa_word[`MFR_SA0_MSB:`MFR_SA0_LSB] = st_r.sa0;
      sa_word[`MFR_SA1_MSB:`MFR_SA1_LSB] = st_r.sa1;
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.mac_rst = 1'b0;

      // Field writes honour byte strobes; reserved bits are dropped
      if (wr_take && hit_fifo) begin
         for (int b = 0; b < `MFR_RXLVL_W; b++) begin
            if (wmask[`MFR_RXLVL_LSB + b]) begin
               st_nxt.rx_lvl[b] = pwdata[`MFR_RXLVL_LSB + b];
            end
         end
         // No range clamp: the start logic trusts software here
         for (int b = 0; b < `MFR_TXCNT_W; b++) begin
            if (wmask[`MFR_TXCNT_LSB + b]) begin
               st_nxt.tx_cnt[b] = pwdata[`MFR_TXCNT_LSB + b];
            end
         end
      end
      if (wr_take && hit_sa) begin
         if (wmask[`MFR_SA0_LSB]) begin
            st_nxt.sa0 = pwdata[`MFR_SA0_MSB:`MFR_SA0_LSB];
         end
         if (wmask[`MFR_SA1_LSB]) begin
            st_nxt.sa1 = pwdata[`MFR_SA1_MSB:`MFR_SA1_LSB];
         end
      end

      // Reset is held back while any DMA is busy to keep the bus alive
      case (st_r.srst)
         SRST_IDLE: begin
            if (srst_req) begin
               st_nxt.srst = SRST_WAIT;
            end
         end
         SRST_WAIT: begin
            if (dma_quiet) begin
               st_nxt.srst    = SRST_FIRE;
               st_nxt.mac_rst = 1'b1;
            end
         end
         SRST_FIRE: begin
            // A new request in the completion cycle is kept
            if (srst_req) begin
               st_nxt.srst = SRST_WAIT;
            end else begin
               st_nxt.srst = SRST_IDLE;
            end
         end
         default: begin
            st_nxt.srst = SRST_IDLE;
         end
      endcase

      // The MAC reset also returns this bank to its reset values
      if (st_r.mac_rst) begin
         st_nxt.rx_lvl = `MFR_RXLVL_RST;
         st_nxt.tx_cnt = `MFR_TXCNT_RST;
         st_nxt.sa0    = `MFR_SA_RST;
         st_nxt.sa1    = `MFR_SA_RST;
      end

      st_nxt.rx_trig = rx_flow_en &&
                       (rx_fifo_used >= {1'b0, st_r.rx_lvl});
      st_nxt.tx_go   = tx_pkt_whole ||
                       (tx_pkt_cells >= {3'b000, st_r.tx_cnt});

      if (setup_ph) begin
         st_nxt.slverr = !mapped;
         if (pwrite || !mapped) begin
            st_nxt.rdata = 32'h0000_0000;
         end else if (hit_fifo) begin
            st_nxt.rdata = fifo_word;
         end else if (hit_info) begin
            st_nxt.rdata = info_word;
         end else if (hit_srst) begin
            st_nxt.rdata = srst_word;
         end else begin
            st_nxt.rdata = sa_word;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata                 = st_r.rdata;
   assign pslverr                = st_r.slverr && psel && penable;
   assign rx_flow_trigger        = st_r.rx_trig;
   assign tx_start_allow         = st_r.tx_go;
   assign mac_soft_rst           = st_r.mac_rst;
   assign rx_flow_trigger_level  = st_r.rx_lvl;
   assign tx_start_cell_count    = st_r.tx_cnt;
   assign station_addr_byte_zero = st_r.sa0;
   assign station_addr_byte_one  = st_r.sa1;

endmodule : mfr_regs

// *** mfr_regs_chk.sv ***
`timescale 1ns/100ps
`include "mfr_map.svh"

module mfr_regs_chk #(
   parameter int unsigned TX_FIFO_CELLS = `MFR_TXTOT_RST,
   parameter int unsigned RX_FIFO_CELLS = `MFR_RXTOT_RST
) (
   input wire logic        clock,                 // Clock
   input wire logic        sys_rst,               // Reset
   input wire logic        psel,                  // APB select
   input wire logic        penable,               // APB access phase
   input wire logic        pwrite,                // APB write
   input wire logic        pslverr,               // APB error
   input wire logic [11:0] paddr,                 // APB address
   input wire logic [31:0] pwdata,                // APB write data
   input wire logic [31:0] prdata,                // APB read data
   input wire logic [3:0]  pstrb,                 // APB strobes
   input wire logic        rx_flow_en,            // Rx flow enable
   input wire logic        rx_flow_trigger,       // Rx flow request
   input wire logic        tx_pkt_whole,          // Head packet complete
   input wire logic        tx_start_allow,        // Tx may start
   input wire logic [7:0]  rx_fifo_used,          // Rx occupancy
   input wire logic [7:0]  tx_pkt_cells,          // Head packet cells
   input wire logic        rx_dma_idle,           // Rx DMA idle
   input wire logic        tx_dma_idle,           // Tx DMA idle
   input wire logic        mac_soft_rst,          // MAC reset pulse
   input wire logic [6:0]  rx_flow_trigger_level, // Rx level value
   input wire logic [4:0]  tx_start_cell_count    // Tx count value
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire acc = psel && penable;
   // First edge after reset still sees reset-time inputs, so skip it
   property p_rx_trig;
      !$past(sys_rst) |->
         rx_flow_trigger == $past(rx_flow_en && rx_fifo_used >= rx_flow_trigger_level);
   endproperty
   a_rx_trig: assert property (p_rx_trig) else $error("rx flow trigger wrong");
   property p_tx_go;
      !$past(sys_rst) |->
         tx_start_allow == $past(tx_pkt_whole || tx_pkt_cells >= tx_start_cell_count);
   endproperty
   a_tx_go: assert property (p_tx_go) else $error("tx start wrong");
   property p_srst_idle;
      mac_soft_rst |-> $past(rx_dma_idle && tx_dma_idle);
   endproperty
   a_srst_idle: assert property (p_srst_idle) else $error("reset while dma busy");
   property p_srst_pulse;
      mac_soft_rst |=> !mac_soft_rst;
   endproperty
   a_srst_pulse: assert property (p_srst_pulse) else $error("reset pulse too long");
   property p_srst_reload;
      mac_soft_rst |=> rx_flow_trigger_level == `MFR_RXLVL_RST
         && tx_start_cell_count == `MFR_TXCNT_RST;
   endproperty
   a_srst_reload: assert property (p_srst_reload) else $error("no reload");
   property p_err;
      acc |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c});
   endproperty
   a_err: assert property (p_err) else $error("slave error wrong");
   property p_rsvd;
      acc && !pwrite && paddr == 12'h000 |-> prdata[31:23] == 9'h000 && prdata[15:5] == 11'h000;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_info;
      acc && !pwrite && paddr == 12'h004 |->
         prdata[31:16] == {TX_FIFO_CELLS[7:0], RX_FIFO_CELLS[7:0]};
   endproperty
   a_info: assert property (p_info) else $error("cell totals wrong");
   property p_wr_lvl;
      acc && pwrite && paddr == 12'h000 && pstrb[2] && !mac_soft_rst |=>
         rx_flow_trigger_level == $past(pwdata[22:16]);
   endproperty
   a_wr_lvl: assert property (p_wr_lvl) else $error("rx level not written");
   c_srst: cover property (mac_soft_rst);
   c_err: cover property (acc && pslverr);
   c_trig: cover property (rx_flow_trigger);
endmodule : mfr_regs_chk

bind mfr_regs mfr_regs_chk #(.TX_FIFO_CELLS(TX_FIFO_CELLS), .RX_FIFO_CELLS(RX_FIFO_CELLS))
   mfr_regs_chk_inst (.clock, .sys_rst, .psel, .penable, .pwrite, .pslverr, .paddr, .pwdata,
   .prdata, .pstrb, .rx_flow_en, .rx_flow_trigger, .tx_pkt_whole, .tx_start_allow,
   .rx_fifo_used, .tx_pkt_cells, .rx_dma_idle, .tx_dma_idle, .mac_soft_rst,
   .rx_flow_trigger_level, .tx_start_cell_count);

// *** mfr_dma_model.sv ***
`timescale 1ns/100ps

module mfr_dma_model (
   input  wire logic clock,       // Clock
   input  wire logic sys_rst,     // Reset
   input  wire logic busy,        // Traffic in flight
   output logic      rx_dma_idle, // Rx DMA idle
   output logic      tx_dma_idle  // Tx DMA idle
);
   // Rx drains a cycle after tx, so one idle alone must not fire the reset
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_dma_idle <= 1'b1;
         rx_dma_idle <= 1'b1;
      end else begin
         tx_dma_idle <= !busy;
         rx_dma_idle <= tx_dma_idle && !busy;
      end
   end
endmodule : mfr_dma_model

// *** mfr_regs_test.sv ***
`timescale 1ns/100ps

module mfr_regs_test;
   logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, rerr, busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  pstrb;
   logic        rx_flow_en, rx_flow_trigger, tx_pkt_whole, tx_start_allow;
   logic [7:0]  rx_fifo_used, tx_pkt_cells, station_addr_byte_zero, station_addr_byte_one;
   logic        rx_dma_idle, tx_dma_idle, mac_soft_rst;
   logic [6:0]  rx_flow_trigger_level;
   logic [4:0]  tx_start_cell_count;
   int          fails, compares, pulses, i;
   localparam logic [31:0] RV [4] = '{32'h00020018, 32'h03030101, 32'h0, 32'h0};
   mfr_regs mfr_regs_inst (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .rx_flow_en, .rx_fifo_used, .rx_flow_trigger,
      .tx_pkt_cells, .tx_pkt_whole, .tx_start_allow, .rx_dma_idle, .tx_dma_idle,
      .mac_soft_rst, .rx_flow_trigger_level, .tx_start_cell_count,
      .station_addr_byte_zero, .station_addr_byte_one);
   mfr_dma_model mfr_dma_model_inst (.clock, .sys_rst, .busy, .rx_dma_idle, .tx_dma_idle);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Counted at the falling edge, mid-pulse, so the pulse is seen exactly once
   always @(negedge clock) if (mac_soft_rst === 1'b1) pulses++;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task close_out;
      $display("Counts: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   // Idle cycle before each setup keeps one assignment per signal per step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clock);
      {psel, penable, pwrite} <= {1'b1, 1'b0, w};
      {paddr, pwdata, pstrb} <= {a, d, s};
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   initial begin
      #100000;
      fails++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      close_out;
   end
   initial begin
      {fails, compares, pulses} = '0;
      sys_rst = 1'b1;
      {psel, penable, pwrite, rx_flow_en, tx_pkt_whole, busy} = '0;
      {paddr, pwdata, pstrb, rx_fifo_used, tx_pkt_cells} = '0;
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      for (i = 0; i < 4; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0, 4'h0);
         chk(rdat, RV[i]);
      end
      chk(32'(rx_flow_trigger_level), 32'h02);
      chk(32'(tx_start_cell_count), 32'h18);
      $display("Reset values done");
      apb(1'b1, 12'h000, 32'hfffffff8, 4'hf);
      apb(1'b0, 12'h000, 32'h0, 4'h0);
      chk(rdat, 32'h007f0018);
      apb(1'b1, 12'h000, 32'h00050003, 4'hf);
      for (i = 0; i < 3; i++) begin
         rx_flow_en <= (i != 2);
         rx_fifo_used <= 8'(4 + i);
         tx_pkt_cells <= 8'(1 + i);
         tx_pkt_whole <= (i == 0);
         repeat (2) @(posedge clock);
         chk(32'(rx_flow_trigger), 32'(i == 1));
         chk(32'(tx_start_allow), 32'(i != 1));
      end
      chk(32'(rx_flow_trigger_level), 32'h05);
      chk(32'(tx_start_cell_count), 32'h03);
      apb(1'b1, 12'h004, 32'h0, 4'hf);
      apb(1'b0, 12'h004, 32'h0, 4'h0);
      chk(rdat, 32'h03030101);
      apb(1'b1, 12'h00c, 32'hffffabcd, 4'h1);
      apb(1'b0, 12'h00c, 32'h0, 4'h0);
      chk(rdat, 32'h000000cd);
      apb(1'b1, 12'h00c, 32'hffffabcd, 4'hf);
      apb(1'b0, 12'h00c, 32'h0, 4'h0);
      chk(rdat, 32'h0000abcd);
      chk(32'(station_addr_byte_zero), 32'hab);
      chk(32'(station_addr_byte_one), 32'hcd);
      apb(1'b1, 12'h010, 32'hffffffff, 4'hf);
      chk(32'(rerr), 32'h1);
      apb(1'b0, 12'h010, 32'h0, 4'h0);
      chk(rdat, 32'h0);
      $display("Register access done");
      apb(1'b1, 12'h008, 32'h0, 4'h1);
      apb(1'b1, 12'h008, 32'h1, 4'h0);
      apb(1'b0, 12'h008, 32'h0, 4'h0);
      chk(rdat, 32'h0);
      busy <= 1'b1;
      apb(1'b1, 12'h008, 32'h1, 4'h1);
      apb(1'b0, 12'h008, 32'h0, 4'h0);
      chk(rdat, 32'h1);
      repeat (20) @(posedge clock);
      chk(32'(pulses), 32'h0);
      busy <= 1'b0;
      for (i = 0; i < 20 && rdat[0] !== 1'b0; i++) apb(1'b0, 12'h008, 32'h0, 4'h0);
      chk(rdat, 32'h0);
      chk(32'(pulses), 32'h1);
      apb(1'b0, 12'h000, 32'h0, 4'h0);
      chk(rdat, 32'h00020018);
      apb(1'b0, 12'h00c, 32'h0, 4'h0);
      chk(rdat, 32'h0);
      chk(32'(tx_start_cell_count), 32'h18);
      $display("Soft reset done");
      close_out;
   end
endmodule : mfr_regs_test
